// >>> design/hmr_map.svh
// Register offsets, field positions, reset values and codes of the readout
`ifndef HMR_MAP_SVH
`define HMR_MAP_SVH

// ==========================================================
// Register offsets
`define HMR_READING_BASE     8'h20
`define HMR_READING_LAST     8'h27
`define HMR_REMOTE1_READING  8'h25
`define HMR_INTERNAL_READING 8'h26
`define HMR_REMOTE2_READING  8'h27
`define HMR_STATUS_FIRST     8'h41
`define HMR_STATUS_SECOND    8'h42
`define HMR_VOLTAGE_ID       8'h43
`define HMR_LIMIT_BASE       8'h44
`define HMR_LIMIT_LAST       8'h53
`define HMR_INTERNAL_LOW     8'h50
`define HMR_INTERNAL_HIGH    8'h51
`define HMR_DIODE_ENABLE     8'h7d

// ==========================================================
// First status register fields
`define HMR_S1_V25           0
`define HMR_S1_VCCP          1
`define HMR_S1_VCC           2
`define HMR_S1_V5            3
`define HMR_S1_INTERNAL      4
`define HMR_S1_REMOTE1       5
`define HMR_S1_REMOTE2       6

// ==========================================================
// Second status register fields
`define HMR_S2_V12           0
`define HMR_S2_FAULT1        1
`define HMR_S2_FAULT2        2

// ==========================================================
// Diode enable fields
`define HMR_EN_REMOTE1       0
`define HMR_EN_REMOTE2       1

// ==========================================================
// Codes and reset values
`define HMR_NOMINAL_CODE     8'hc0
`define HMR_FAULT_CODE       8'h80
`define HMR_DISABLED_CODE    8'h00
`define HMR_READING_RST      8'h00
`define HMR_VLOW_RST         8'h00
`define HMR_VHIGH_RST        8'hff
`define HMR_TLOW_RST         8'h81
`define HMR_THIGH_RST        8'h7f
`define HMR_ENABLE_RST       2'b11
`define HMR_VID_WIDTH        5

`endif

// >>> design/hmr_pkg.sv
// Types shared by the readout modules
package hmr_pkg;

	// ==========================================================
	// Conversion channels, in reading register order
	typedef enum logic [2:0]
	{
		HMR_CH_V25,
		HMR_CH_VCCP,
		HMR_CH_VCC,
		HMR_CH_V5,
		HMR_CH_V12,
		HMR_CH_REMOTE1,
		HMR_CH_INTERNAL,
		HMR_CH_REMOTE2
	} hmr_chan_e;

	typedef logic [7:0] hmr_byte_t;

endpackage

// >>> design/hmr_limit_check.sv
// Window comparator of one reading against its low and high limits
`timescale 1ns/100ps

module hmr_limit_check
(
	input  wire logic [7:0] value,
	input  wire logic [7:0] low,
	input  wire logic [7:0] high,
	input  wire logic       is_signed,
	output logic            violation
);

	// ==========================================================
	// Compare
	always_comb
	begin
		if (is_signed)
			violation = ($signed(value) < $signed(low)) ||
				($signed(value) > $signed(high));
		else
			violation = (value < low) || (value > high);
	end

endmodule

// >>> design/hmr_readout.sv
// Hardware monitor readout: readings, limit checks, status and voltage ID
`timescale 1ns/100ps
`include "hmr_map.svh"

// Operation
// - Nominal supply input reads 192, except core
// - Store voltage result, then compare with limits
// - Out-of-limit voltage sets its status bit
// - Capture voltage ID inputs at 43h
// - Internal temperature stored signed at 26h
// - Internal temperature checked against 50h, 51h
// - Remote one at 25h, remote two 27h
// - Remote limit violation sets bit in 41h
// - Per-diode fault bit in 42h on short/open
// - Faulty diode reading replaced by 80h
// - Fault code trips remote limit error normally
// - Signed degrees, 81h..7Fh; 80h means error
// - Zones: remote one, internal, remote two
// - Negative-to-ground fault keeps conversion result
// - Disabled diode: no fault bit, loads 00h
// - Status read clears bits unless condition persists
module hmr_readout
#(
	parameter int VID_WIDTH = `HMR_VID_WIDTH
)
(
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   conv_valid,
	input  wire hmr_pkg::hmr_chan_e     conv_channel,
	input  wire logic [7:0]             conv_data,
	input  wire logic                   remote1_fault,
	input  wire logic                   remote1_fault_neg_gnd,
	input  wire logic                   remote2_fault,
	input  wire logic                   remote2_fault_neg_gnd,
	input  wire logic [VID_WIDTH-1:0]   voltage_id_inputs,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [7:0]                  reg_rdata,
	output logic [7:0]                  zone1_temp,
	output logic [7:0]                  zone2_temp,
	output logic [7:0]                  zone3_temp
);

	// ==========================================================
	// Reset release
	logic       rst_meta_n;
	logic       rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// Pin synchronisers
	// A pin change is taken once the second and third stages agree,
	// which rejects a single-cycle glitch.
	localparam int PINS = VID_WIDTH + 4;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_s1;
	logic [PINS-1:0] pin_s2;
	logic [PINS-1:0] pin_s3;
	logic [PINS-1:0] pin_stable;
	logic [PINS-1:0] next_pin_stable;

	assign pin_raw = {voltage_id_inputs, remote2_fault_neg_gnd,
		remote2_fault, remote1_fault_neg_gnd, remote1_fault};

	always_comb
	begin
		next_pin_stable = (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
	end

	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pin_s1     <= '0;
			pin_s2     <= '0;
			pin_s3     <= '0;
			pin_stable <= '0;
		end
		else
		begin
			pin_s1     <= pin_raw;
			pin_s2     <= pin_s1;
			pin_s3     <= pin_s2;
			pin_stable <= next_pin_stable;
		end
	end

	logic flt1;
	logic flt1_ng;
	logic flt2;
	logic flt2_ng;

	assign flt1    = pin_stable[0];
	assign flt1_ng = pin_stable[1];
	assign flt2    = pin_stable[2];
	assign flt2_ng = pin_stable[3];

	// ==========================================================
	// Register state
	logic [7:0]           reading [0:7];
	logic [7:0]           next_reading [0:7];
	logic [7:0]           lim_low [0:7];
	logic [7:0]           next_lim_low [0:7];
	logic [7:0]           lim_high [0:7];
	logic [7:0]           next_lim_high [0:7];
	logic [7:0]           status1;
	logic [7:0]           next_status1;
	logic [7:0]           status2;
	logic [7:0]           next_status2;
	logic [7:0]           vid_reg;
	logic [7:0]           next_vid_reg;
	logic [1:0]           diode_en;
	logic [1:0]           next_diode_en;
	logic [7:0]           next_reg_rdata;
	logic [7:0]           viol;
	logic [7:0]           cond1;
	logic [7:0]           cond2;
	logic                 fault1_bit;
	logic                 fault2_bit;

	// ==========================================================
	// Limit comparators on stored readings
	// Channels from the remote diode upward hold temperatures.
	for (genvar i = 0; i < 8; i++)
	begin : g_chk
		hmr_limit_check u_chk
		(
			.value     (reading[i]),
			.low       (lim_low[i]),
			.high      (lim_high[i]),
			.is_signed (i >= int'(hmr_pkg::HMR_CH_REMOTE1)),
			.violation (viol[i])
		);
	end

	// ==========================================================
	// Helpers
	function automatic logic is_limit(input logic [7:0] a);
		is_limit = (a >= `HMR_LIMIT_BASE) && (a <= `HMR_LIMIT_LAST);
	endfunction

	function automatic logic [2:0] limit_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - `HMR_LIMIT_BASE;
		limit_index = d[3:1];
	endfunction

	// Remote diode result, with fault substitution
	function automatic logic [7:0] remote_value(
		input logic [7:0] data,
		input logic       fault,
		input logic       neg_gnd,
		input logic       enabled);
		remote_value = data;
		if (fault && !neg_gnd)
		begin
			if (enabled)
				remote_value = `HMR_FAULT_CODE;
			else
				remote_value = `HMR_DISABLED_CODE;
		end
	endfunction

	// ==========================================================
	// Fault and limit conditions
	always_comb
	begin
		fault1_bit = flt1 && diode_en[`HMR_EN_REMOTE1];
		fault2_bit = flt2 && diode_en[`HMR_EN_REMOTE2];
		cond1 = '0;
		cond1[`HMR_S1_V25]      = viol[hmr_pkg::HMR_CH_V25];
		cond1[`HMR_S1_VCCP]     = viol[hmr_pkg::HMR_CH_VCCP];
		cond1[`HMR_S1_VCC]      = viol[hmr_pkg::HMR_CH_VCC];
		cond1[`HMR_S1_V5]       = viol[hmr_pkg::HMR_CH_V5];
		cond1[`HMR_S1_INTERNAL] = viol[hmr_pkg::HMR_CH_INTERNAL];
		cond1[`HMR_S1_REMOTE1]  = viol[hmr_pkg::HMR_CH_REMOTE1];
		cond1[`HMR_S1_REMOTE2]  = viol[hmr_pkg::HMR_CH_REMOTE2];
		cond2 = '0;
		cond2[`HMR_S2_V12]      = viol[hmr_pkg::HMR_CH_V12];
		cond2[`HMR_S2_FAULT1]   = fault1_bit;
		cond2[`HMR_S2_FAULT2]   = fault2_bit;
	end

	// ==========================================================
	// Next register values
	always_comb
	begin
		next_reading  = reading;
		next_lim_low  = lim_low;
		next_lim_high = lim_high;
		next_diode_en = diode_en;
		next_vid_reg  = '0;
		next_vid_reg[VID_WIDTH-1:0] = pin_stable[PINS-1:4];

		// Whole byte lands in one edge, so reads never see a mix
		if (conv_valid)
		begin
			case (conv_channel)
				hmr_pkg::HMR_CH_REMOTE1:
					next_reading[conv_channel] = remote_value(conv_data,
						flt1, flt1_ng, diode_en[`HMR_EN_REMOTE1]);
				hmr_pkg::HMR_CH_REMOTE2:
					next_reading[conv_channel] = remote_value(conv_data,
						flt2, flt2_ng, diode_en[`HMR_EN_REMOTE2]);
				hmr_pkg::HMR_CH_INTERNAL:
					next_reading[conv_channel] = conv_data;
				default:
					next_reading[conv_channel] = conv_data;
			endcase
		end

		if (reg_wr && is_limit(reg_addr))
		begin
			if (reg_addr[0])
				next_lim_high[limit_index(reg_addr)] = reg_wdata;
			else
				next_lim_low[limit_index(reg_addr)] = reg_wdata;
		end
		if (reg_wr && reg_addr == `HMR_DIODE_ENABLE)
			next_diode_en = reg_wdata[1:0];

		// A read clears, but a present condition sets again at once
		if (reg_rd && reg_addr == `HMR_STATUS_FIRST)
			next_status1 = cond1;
		else
			next_status1 = status1 | cond1;
		if (reg_rd && reg_addr == `HMR_STATUS_SECOND)
			next_status2 = cond2;
		else
			next_status2 = status2 | cond2;

		next_reg_rdata = reg_rdata;
		if (reg_rd)
		begin
			next_reg_rdata = 8'h00;
			if (reg_addr >= `HMR_READING_BASE && reg_addr <= `HMR_READING_LAST)
				next_reg_rdata = reading[reg_addr[2:0]];
			else if (is_limit(reg_addr))
				next_reg_rdata = reg_addr[0] ? lim_high[limit_index(reg_addr)]
					: lim_low[limit_index(reg_addr)];
			else if (reg_addr == `HMR_STATUS_FIRST)
				next_reg_rdata = status1;
			else if (reg_addr == `HMR_STATUS_SECOND)
				next_reg_rdata = status2;
			else if (reg_addr == `HMR_VOLTAGE_ID)
				next_reg_rdata = vid_reg;
			else if (reg_addr == `HMR_DIODE_ENABLE)
				next_reg_rdata = {6'h00, diode_en};
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			for (int i = 0; i < 8; i++)
			begin
				reading[i]  <= `HMR_READING_RST;
				lim_low[i]  <= (i >= 5) ? `HMR_TLOW_RST : `HMR_VLOW_RST;
				lim_high[i] <= (i >= 5) ? `HMR_THIGH_RST : `HMR_VHIGH_RST;
			end
			status1   <= 8'h00;
			status2   <= 8'h00;
			vid_reg   <= 8'h00;
			diode_en  <= `HMR_ENABLE_RST;
			reg_rdata <= 8'h00;
		end
		else
		begin
			reading   <= next_reading;
			lim_low   <= next_lim_low;
			lim_high  <= next_lim_high;
			status1   <= next_status1;
			status2   <= next_status2;
			vid_reg   <= next_vid_reg;
			diode_en  <= next_diode_en;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ==========================================================
	// Zone temperatures for fan control
	assign zone1_temp = reading[hmr_pkg::HMR_CH_REMOTE1];
	assign zone2_temp = reading[hmr_pkg::HMR_CH_INTERNAL];
	assign zone3_temp = reading[hmr_pkg::HMR_CH_REMOTE2];

endmodule

// >>> dv/hmr_readout_sva.sv
// Port checker of the readout
`timescale 1ns/100ps

module hmr_readout_sva
#(
	parameter int VID_WIDTH = 5
)
(
	input wire logic		mclk,
	input wire logic		rst_n,
	input wire logic		conv_valid,
	input wire hmr_pkg::hmr_chan_e	conv_channel,
	input wire logic [7:0]		conv_data,
	input wire logic		remote1_fault,
	input wire logic		remote1_fault_neg_gnd,
	input wire logic		remote2_fault,
	input wire logic		remote2_fault_neg_gnd,
	input wire logic [VID_WIDTH-1:0]	voltage_id_inputs,
	input wire logic [7:0]		reg_addr,
	input wire logic		reg_rd,
	input wire logic [7:0]		reg_rdata,
	input wire logic [7:0]		zone1_temp,
	input wire logic [7:0]		zone2_temp,
	input wire logic [7:0]		zone3_temp
);
	// ==========================================================
	// Channel strobes
	wire r1 = conv_valid && conv_channel == hmr_pkg::HMR_CH_REMOTE1;
	wire ri = conv_valid && conv_channel == hmr_pkg::HMR_CH_INTERNAL;
	wire r2 = conv_valid && conv_channel == hmr_pkg::HMR_CH_REMOTE2;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Properties
	// Five quiet cycles cover the pin synchroniser
	property p_r1;
		(!remote1_fault)[*5] ##0 r1 |=> zone1_temp == $past(conv_data);
	endproperty
	a_r1: assert property (p_r1)
		else $error("zone one reading wrong");
	property p_r1f;
		(remote1_fault && !remote1_fault_neg_gnd)[*5] ##0 r1
			|=> zone1_temp inside {8'h80, 8'h00};
	endproperty
	a_r1f: assert property (p_r1f)
		else $error("faulty diode not replaced");
	property p_r2n;
		(remote2_fault && remote2_fault_neg_gnd)[*5] ##0 r2
			|=> zone3_temp == $past(conv_data);
	endproperty
	a_r2n: assert property (p_r2n)
		else $error("ground fault reading replaced");
	property p_int;
		ri |=> zone2_temp == $past(conv_data);
	endproperty
	a_int: assert property (p_int)
		else $error("internal reading wrong");
	property p_hold;
		!ri |=> $stable(zone2_temp);
	endproperty
	a_hold: assert property (p_hold)
		else $error("reading changed without conversion");
	property p_rd26;
		reg_rd && reg_addr == 8'h26 && !conv_valid
			|=> reg_rdata == $past(zone2_temp);
	endproperty
	a_rd26: assert property (p_rd26)
		else $error("internal register read wrong");
	property p_rdhold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdhold: assert property (p_rdhold)
		else $error("read data moved without read");
	property p_vid;
		$stable(voltage_id_inputs)[*5] ##0 (reg_rd && reg_addr == 8'h43)
			|=> reg_rdata == 8'($past(voltage_id_inputs));
	endproperty
	a_vid: assert property (p_vid)
		else $error("voltage id read wrong");
endmodule

// >>> dv/hmr_front_model.sv
// Behavioural sensor front end delivering conversion results
`timescale 1ns/100ps

module hmr_front_model
(
	input wire logic		mclk,
	input wire logic		req,
	input wire hmr_pkg::hmr_chan_e	req_ch,
	input wire logic [7:0]		req_data,
	output logic			conv_valid,
	output hmr_pkg::hmr_chan_e	conv_channel,
	output logic [7:0]		conv_data
);
	initial
	begin
		conv_valid = 1'b0;
		conv_channel = hmr_pkg::HMR_CH_V25;
		conv_data = 8'h00;
	end

	// Idle channel and data lines toggle so nothing relies on a held value
	always @(posedge mclk)
	begin
		conv_valid <= req;
		conv_channel <= req ? req_ch : hmr_pkg::hmr_chan_e'(~conv_channel);
		conv_data <= req ? req_data : ~conv_data;
	end
endmodule

// >>> dv/hmr_readout_bench.sv
// Self-checking bench of the readout
`timescale 1ns/100ps

module hmr_readout_bench;
	logic			mclk, rst_n, req, reg_wr, reg_rd, rd_d;
	logic			f1, n1, f2, n2, conv_valid;
	hmr_pkg::hmr_chan_e	req_ch, conv_channel;
	logic [7:0]		req_data, conv_data, reg_addr, reg_wdata;
	logic [7:0]		reg_rdata, d, e, z1, z2, z3;
	logic [4:0]		vid;
	logic [7:0]		exp_q[$];
	int			n_fail, n_tests, cyc;

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	hmr_front_model u_model (.mclk(mclk), .req(req), .req_ch(req_ch),
		.req_data(req_data), .conv_valid(conv_valid),
		.conv_channel(conv_channel), .conv_data(conv_data));

	hmr_readout dut_u (.mclk(mclk), .rst_n(rst_n), .conv_valid(conv_valid),
		.conv_channel(conv_channel), .conv_data(conv_data),
		.remote1_fault(f1), .remote1_fault_neg_gnd(n1),
		.remote2_fault(f2), .remote2_fault_neg_gnd(n2),
		.voltage_id_inputs(vid), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .zone1_temp(z1), .zone2_temp(z2),
		.zone3_temp(z3));

	// ==========================================================
	// Drivers
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		exp_q.push_back(v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask

	// Model adds one cycle, status lands two edges later
	task automatic cv(input hmr_pkg::hmr_chan_e c, input logic [7:0] v);
		req_ch <= c;
		req_data <= v;
		req <= 1'b1;
		@(posedge mclk);
		req <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic pins(input logic [3:0] p);
		{f1, n1, f2, n2} <= p;
		repeat (5) @(posedge mclk);
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Monitor and timeout
	always @(posedge mclk)
		rd_d <= reg_rd;

	always @(negedge mclk)
		if (rd_d === 1'b1)
		begin
			e = exp_q.pop_front();
			n_tests++;
			if (reg_rdata !== e)
			begin
				$display("MISMATCH %0t got %h exp %h", $time, reg_rdata, e);
				n_fail++;
			end
		end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			end_sim();
		end
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		{rst_n, req, reg_wr, reg_rd, rd_d, f1, n1, f2, n2} = 9'h000;
		{req_data, reg_addr, reg_wdata, vid} = 29'h0;
		req_ch = hmr_pkg::HMR_CH_V25;
		void'($urandom(32'hd7e0));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(8'h41, 8'h00);
		rd(8'h50, 8'h81);
		rd(8'h51, 8'h7f);
		rd(8'h00, 8'h00);
		$display("test 1 done");
		for (int i = 0; i < 5; i++)
		begin
			d = 8'($urandom);
			cv(hmr_pkg::hmr_chan_e'(i), d);
			rd(8'h20 + 8'(i), d);
		end
		wr(8'h4b, 8'h80);
		cv(hmr_pkg::HMR_CH_V5, 8'hc0);
		rd(8'h41, 8'h08);
		rd(8'h41, 8'h08);
		wr(8'h4b, 8'hff);
		rd(8'h41, 8'h08);
		rd(8'h41, 8'h00);
		wr(8'h4d, 8'h10);
		cv(hmr_pkg::HMR_CH_V12, 8'h11);
		wr(8'h4d, 8'hff);
		rd(8'h42, 8'h01);
		// Load the reading first, so an old random value below the
		// new low limit cannot set the status bit early.
		cv(hmr_pkg::HMR_CH_V25, 8'h50);
		wr(8'h44, 8'h50);
		rd(8'h41, 8'h00);
		cv(hmr_pkg::HMR_CH_V25, 8'h4f);
		rd(8'h41, 8'h01);
		$display("test 2 done");
		cv(hmr_pkg::HMR_CH_INTERNAL, 8'hce);
		rd(8'h26, 8'hce);
		wr(8'h44, 8'h00);
		rd(8'h41, 8'h01);
		wr(8'h50, 8'he7);
		rd(8'h41, 8'h10);
		$display("test 3 done");
		pins(4'b1011);
		cv(hmr_pkg::HMR_CH_REMOTE1, 8'h19);
		cv(hmr_pkg::HMR_CH_REMOTE2, 8'h32);
		rd(8'h25, 8'h80);
		rd(8'h27, 8'h32);
		rd(8'h42, 8'h06);
		rd(8'h41, 8'h30);
		wr(8'h25, 8'h55);
		rd(8'h25, 8'h80);
		wr(8'h7d, 8'h00);
		cv(hmr_pkg::HMR_CH_REMOTE1, 8'h19);
		rd(8'h25, 8'h00);
		rd(8'h42, 8'h06);
		rd(8'h42, 8'h00);
		$display("test 4 done");
		pins(4'b0000);
		wr(8'h7d, 8'h03);
		d = 8'($urandom_range(254)) - 8'd127;
		cv(hmr_pkg::HMR_CH_REMOTE2, d);
		rd(8'h27, d);
		d = 8'($urandom_range(254)) - 8'd127;
		cv(hmr_pkg::HMR_CH_REMOTE1, d);
		rd(8'h25, d);
		vid <= 5'($urandom);
		repeat (5) @(posedge mclk);
		rd(8'h43, {3'h0, vid});
		$display("test 5 done");
		end_sim();
	end
endmodule

bind hmr_readout hmr_readout_sva #(.VID_WIDTH(VID_WIDTH)) u_sva
(
	.mclk(mclk), .rst_n(rst_n), .conv_valid(conv_valid),
	.conv_channel(conv_channel), .conv_data(conv_data),
	.remote1_fault(remote1_fault),
	.remote1_fault_neg_gnd(remote1_fault_neg_gnd),
	.remote2_fault(remote2_fault),
	.remote2_fault_neg_gnd(remote2_fault_neg_gnd),
	.voltage_id_inputs(voltage_id_inputs), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .zone1_temp(zone1_temp),
	.zone2_temp(zone2_temp), .zone3_temp(zone3_temp)
);
